// [src/csf_pkg.sv]
// constants shared by the clock start-up and fail-safe controller
package csf_pkg;
    // ==========================================================
    // clock rates and timing
    localparam int unsigned SYS_CLK_KHZ = 100000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned FAST_OSC_KHZ = 8000;
    localparam int unsigned SLOW_OSC_KHZ = 31;
    localparam int unsigned FAST_DIV = SYS_CLK_KHZ / FAST_OSC_KHZ;
    localparam int unsigned SLOW_DIV = SYS_CLK_KHZ / SLOW_OSC_KHZ;
    localparam int unsigned OST_PERIODS = 1024;
    localparam int unsigned CPU_DELAY_NS = 5000;
    localparam int unsigned CPU_DELAY_CYC = (CPU_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int OST_W = 11;
    localparam int SLOW_W = 12;
    localparam int FAST_W = 4;
    localparam int DLY_W = 10;
    localparam int IFS_W = 3;
    localparam int PRE_W = 7;
    localparam int MODE_W = 3;

    // ==========================================================
    // register map
    localparam logic [ADDR_W-1:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OSC_STAT = 4'h4;
    localparam int CTRL_SCS = 0;
    localparam int CTRL_TWO_SPEED = 1;
    localparam int CTRL_MON_EN = 2;
    localparam int CTRL_DONE = 3;
    localparam int CTRL_IFS_LO = 4;
    localparam int STAT_FAIL_FLAG = 0;
    localparam int STAT_FAILSAFE = 1;
    localparam int STAT_SLEEP = 2;
    localparam logic [IFS_W-1:0] IFS_RESET = 3'h6;
    localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

    // ==========================================================
    // clock mode codes on the configuration input
    localparam logic [MODE_W-1:0] MODE_LP = 3'h0;
    localparam logic [MODE_W-1:0] MODE_XT = 3'h1;
    localparam logic [MODE_W-1:0] MODE_HS = 3'h2;
    localparam logic [MODE_W-1:0] MODE_RC = 3'h3;
    localparam logic [MODE_W-1:0] MODE_EC = 3'h4;
    localparam logic [MODE_W-1:0] MODE_INT = 3'h5;

    // system clock source codes
    localparam logic SRC_EXT = 1'b0;
    localparam logic SRC_INT = 1'b1;

    // controller states
    typedef enum logic [2:0] {
        CSF_ST_POWER_UP_DELAY_TIMER,
        CSF_ST_OST,
        CSF_ST_CPU_DLY,
        CSF_ST_RUN,
        CSF_ST_SLEEP
    } csf_state_t;
endpackage

// [src/csf_clock_control.sv]
// clock start-up counter, source selection and fail-safe clock monitor
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module csf_clock_control (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [csf_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [csf_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [csf_pkg::DATA_W-1:0] reg_rdata_out,
    // configuration and core events
    input wire logic [csf_pkg::MODE_W-1:0] clock_mode_in,
    input wire logic power_up_delay_en_in,
    input wire logic power_up_delay_done_in,
    input wire logic sleep_cmd_in,
    input wire logic wake_in,
    // external oscillator pin
    input wire logic primary_osc_input_pin_in,
    // clock control outputs
    output logic sys_clk_src_out,
    output logic sys_clk_run_out,
    output logic cpu_hold_out,
    output logic ccp_clk_src_out,
    output logic internal_osc_clock_out,
    output logic [csf_pkg::IFS_W-1:0] internal_freq_select_out,
    output logic secondary_osc_pin_gpio_out,
    output logic failsafe_out,
    output logic osc_failure_flag_out
);

    // ==========================================================
    // helpers
    function automatic logic is_crystal(input logic [csf_pkg::MODE_W-1:0] mode);
        is_crystal = (mode == csf_pkg::MODE_LP) || (mode == csf_pkg::MODE_XT)
                     || (mode == csf_pkg::MODE_HS);
    endfunction

    // prescale mask: frequency select 7 is the full fast rate, each step down to 1 halves it; 0 is the slow rate
    function automatic logic [csf_pkg::PRE_W-1:0] pre_mask(input logic [csf_pkg::IFS_W-1:0] ifs);
        pre_mask = csf_pkg::PRE_W'((8'h80 >> ifs) - 8'h01);
    endfunction

    // ==========================================================
    // declarations
    csf_pkg::csf_state_t state_reg, state_next;
    logic failsafe_reg, failsafe_next;
    logic flag_reg;
    logic scs_reg, two_speed_reg, mon_en_reg, done_reg;
    logic [csf_pkg::IFS_W-1:0] ifs_reg;
    logic fast_start_reg;
    logic [csf_pkg::OST_W-1:0] ost_cnt_reg;
    logic [csf_pkg::DLY_W-1:0] dly_cnt_reg;
    logic [csf_pkg::FAST_W-1:0] fast_cnt_reg;
    logic [csf_pkg::SLOW_W-1:0] slow_cnt_reg;
    logic [csf_pkg::PRE_W-1:0] pre_cnt_reg;
    logic pin_prev_reg, edge_seen_reg, mon_armed_reg;
    logic [csf_pkg::DATA_W-1:0] rdata_reg;
    logic src_reg, run_reg, hold_reg, ccp_src_reg, int_tick_reg, gpio_reg;
    logic use_int, pin_edge, fast_tick, slow_tick, osc_on;
    logic mon_active, fail_det, ost_end, dly_end;
    logic wr_ctrl, wr_stat, scs_change, flag_clr;

    // ==========================================================
    // combinational decode
    assign use_int = scs_reg || (clock_mode_in == csf_pkg::MODE_INT);
    assign pin_edge = primary_osc_input_pin_in && !pin_prev_reg;
    assign osc_on = (state_reg != csf_pkg::CSF_ST_SLEEP);
    assign fast_tick = osc_on && (fast_cnt_reg == csf_pkg::FAST_W'(csf_pkg::FAST_DIV - 1));
    assign slow_tick = osc_on && (slow_cnt_reg == csf_pkg::SLOW_W'(csf_pkg::SLOW_DIV - 1));
    assign ost_end = pin_edge && (ost_cnt_reg == csf_pkg::OST_W'(csf_pkg::OST_PERIODS - 1));
    assign dly_end = (dly_cnt_reg == csf_pkg::DLY_W'(csf_pkg::CPU_DELAY_CYC - 1));
    assign wr_ctrl = reg_wr_in && (reg_addr_in == csf_pkg::ADDR_OSC_CTRL);
    assign wr_stat = reg_wr_in && (reg_addr_in == csf_pkg::ADDR_OSC_STAT);
    assign scs_change = wr_ctrl && (reg_wdata_in[csf_pkg::CTRL_SCS] != scs_reg);
    // a clear request only lands once the fail-safe condition is gone
    assign flag_clr = wr_stat && reg_wdata_in[csf_pkg::STAT_FAIL_FLAG] && !failsafe_reg;

    // monitor only watches a running external clock; idle during start-up
    assign mon_active = mon_en_reg && !use_int && !failsafe_reg
                        && (state_reg == csf_pkg::CSF_ST_RUN);
    assign fail_det = mon_active && mon_armed_reg && slow_tick && !edge_seen_reg && !pin_edge;

    // ==========================================================
    // next state and fail-safe
    always_comb
    begin
        state_next = state_reg;
        failsafe_next = failsafe_reg;
        unique case (state_reg)
            csf_pkg::CSF_ST_POWER_UP_DELAY_TIMER:
            begin
                if (is_crystal(clock_mode_in) && !use_int)
                begin
                    if (!power_up_delay_en_in || power_up_delay_done_in)
                        state_next = csf_pkg::CSF_ST_OST;
                end
                else if (use_int)
                    state_next = csf_pkg::CSF_ST_CPU_DLY;
                else
                    state_next = csf_pkg::CSF_ST_RUN;
            end
            csf_pkg::CSF_ST_OST:
            begin
                if (ost_end)
                    state_next = csf_pkg::CSF_ST_RUN;
            end
            csf_pkg::CSF_ST_CPU_DLY:
            begin
                if (dly_end)
                    state_next = csf_pkg::CSF_ST_RUN;
            end
            csf_pkg::CSF_ST_RUN:
            begin
                if (sleep_cmd_in)
                    state_next = csf_pkg::CSF_ST_SLEEP;
            end
            csf_pkg::CSF_ST_SLEEP:
            begin
                // wake skips the power-up delay: crystal counts, internal delays
                if (wake_in && is_crystal(clock_mode_in) && !use_int)
                    state_next = csf_pkg::CSF_ST_OST;
                else if (wake_in && use_int)
                    state_next = csf_pkg::CSF_ST_CPU_DLY;
                else if (wake_in)
                    state_next = csf_pkg::CSF_ST_RUN;
            end
        endcase
        // failure entry and the two ways out of fail-safe
        if (fail_det)
            failsafe_next = 1'b1;
        else if (scs_change || (state_next == csf_pkg::CSF_ST_SLEEP))
            failsafe_next = 1'b0;
    end

    // ==========================================================
    // state registers; clk_en low freezes everything, so a stopped clock keeps all state but loses events seen only then
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_reg <= csf_pkg::CSF_ST_POWER_UP_DELAY_TIMER;
            failsafe_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_reg <= state_next;
            failsafe_reg <= failsafe_next;
        end
    end

    // start-up counter on primary pin edges and cpu delay counter
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ost_cnt_reg <= '0;
            dly_cnt_reg <= '0;
            pin_prev_reg <= 1'b0;
            fast_start_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pin_prev_reg <= primary_osc_input_pin_in;
            if (state_reg != csf_pkg::CSF_ST_OST)
                ost_cnt_reg <= '0;
            else if (pin_edge)
                ost_cnt_reg <= ost_cnt_reg + 1'b1;
            if (state_reg != csf_pkg::CSF_ST_CPU_DLY)
                dly_cnt_reg <= '0;
            else
                dly_cnt_reg <= dly_cnt_reg + 1'b1;
            // two-speed choice is latched as the count starts
            if (state_reg != csf_pkg::CSF_ST_OST)
                fast_start_reg <= two_speed_reg || mon_en_reg;
        end
    end

    // internal oscillators derived from the system clock, stopped in sleep
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fast_cnt_reg <= '0;
            slow_cnt_reg <= '0;
            pre_cnt_reg <= '0;
        end
        else if (clk_en_in && osc_on)
        begin
            fast_cnt_reg <= fast_tick ? '0 : fast_cnt_reg + 1'b1;
            slow_cnt_reg <= slow_tick ? '0 : slow_cnt_reg + 1'b1;
            if (fast_tick)
                pre_cnt_reg <= pre_cnt_reg + 1'b1;
        end
    end

    // monitor window: any rising pin edge between two slow ticks proves the clock alive
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            edge_seen_reg <= 1'b0;
            mon_armed_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (!mon_active)
            begin
                edge_seen_reg <= 1'b0;
                mon_armed_reg <= 1'b0;
            end
            else if (slow_tick)
            begin
                // the first window is partial, so it only arms the check
                edge_seen_reg <= 1'b0;
                mon_armed_reg <= 1'b1;
            end
            else if (pin_edge)
                edge_seen_reg <= 1'b1;
        end
    end

    // software control bits; frequency select stays writable in fail-safe
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            scs_reg <= 1'b0;
            two_speed_reg <= 1'b0;
            mon_en_reg <= 1'b0;
            ifs_reg <= csf_pkg::IFS_RESET;
        end
        else if (clk_en_in && wr_ctrl)
        begin
            scs_reg <= reg_wdata_in[csf_pkg::CTRL_SCS];
            two_speed_reg <= reg_wdata_in[csf_pkg::CTRL_TWO_SPEED];
            mon_en_reg <= reg_wdata_in[csf_pkg::CTRL_MON_EN];
            ifs_reg <= reg_wdata_in[csf_pkg::CTRL_IFS_LO +: csf_pkg::IFS_W];
        end
    end

    // failure flag: a failure in the clearing cycle wins over the clear
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            flag_reg <= 1'b0;
        else if (clk_en_in)
        begin
            if (fail_det)
                flag_reg <= 1'b1;
            else if (flag_clr)
                flag_reg <= 1'b0;
        end
    end

    // start-up done: low while the internal clock covers start-up
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            done_reg <= 1'b0;
        else if (clk_en_in)
            done_reg <= (state_next == csf_pkg::CSF_ST_RUN);
    end

    // clock outputs; source, ccp source, run and hold computed from next values so they move together
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            src_reg <= csf_pkg::SRC_INT;
            run_reg <= 1'b0;
            hold_reg <= 1'b1;
            ccp_src_reg <= csf_pkg::SRC_INT;
            int_tick_reg <= 1'b0;
            gpio_reg <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // internal while starting, in fail-safe or when selected
            src_reg <= (state_next != csf_pkg::CSF_ST_RUN) || failsafe_next || use_int
                       ? csf_pkg::SRC_INT : csf_pkg::SRC_EXT;
            ccp_src_reg <= (failsafe_next || use_int)
                           ? csf_pkg::SRC_INT : csf_pkg::SRC_EXT;
            run_reg <= (state_next != csf_pkg::CSF_ST_SLEEP);
            hold_reg <= (state_next == csf_pkg::CSF_ST_POWER_UP_DELAY_TIMER)
                        || (state_next == csf_pkg::CSF_ST_CPU_DLY)
                        || (state_next == csf_pkg::CSF_ST_SLEEP)
                        || ((state_next == csf_pkg::CSF_ST_OST)
                            && !(two_speed_reg || mon_en_reg));
            int_tick_reg <= (ifs_reg == '0) ? slow_tick
                            : (fast_tick && ((pre_cnt_reg & pre_mask(ifs_reg)) == pre_mask(ifs_reg)));
            gpio_reg <= (clock_mode_in == csf_pkg::MODE_EC);
        end
    end

    // register read, answered in the following cycle
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            rdata_reg <= csf_pkg::RDATA_NONE;
        else if (clk_en_in)
        begin
            rdata_reg <= csf_pkg::RDATA_NONE;
            if (reg_rd_in && (reg_addr_in == csf_pkg::ADDR_OSC_CTRL))
            begin
                rdata_reg[csf_pkg::CTRL_SCS] <= scs_reg;
                rdata_reg[csf_pkg::CTRL_TWO_SPEED] <= two_speed_reg;
                rdata_reg[csf_pkg::CTRL_MON_EN] <= mon_en_reg;
                rdata_reg[csf_pkg::CTRL_DONE] <= done_reg;
                rdata_reg[csf_pkg::CTRL_IFS_LO +: csf_pkg::IFS_W] <= ifs_reg;
            end
            else if (reg_rd_in && (reg_addr_in == csf_pkg::ADDR_OSC_STAT))
            begin
                rdata_reg[csf_pkg::STAT_FAIL_FLAG] <= flag_reg;
                rdata_reg[csf_pkg::STAT_FAILSAFE] <= failsafe_reg;
                rdata_reg[csf_pkg::STAT_SLEEP] <= !run_reg;
            end
        end
    end

    // ==========================================================
    // output wiring
    assign reg_rdata_out = rdata_reg;
    assign sys_clk_src_out = src_reg;
    assign sys_clk_run_out = run_reg;
    assign cpu_hold_out = hold_reg;
    assign ccp_clk_src_out = ccp_src_reg;
    assign internal_osc_clock_out = int_tick_reg;
    assign internal_freq_select_out = ifs_reg;
    assign secondary_osc_pin_gpio_out = gpio_reg;
    assign failsafe_out = failsafe_reg;
    assign osc_failure_flag_out = flag_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    fail_entry_a: assert property (clk_en_in && fail_det |=> failsafe_reg && flag_reg && sys_clk_src_out == csf_pkg::SRC_INT)
        else $error("failure did not switch clock and set flag together");
    failsafe_src_a: assert property (failsafe_reg |-> sys_clk_src_out == csf_pkg::SRC_INT)
        else $error("fail-safe running from external clock");
    ccp_switch_a: assert property (failsafe_reg |-> ccp_clk_src_out == csf_pkg::SRC_INT)
        else $error("pwm unit not on internal clock in fail-safe");
    flag_hold_a: assert property (failsafe_reg && flag_reg |=> flag_reg)
        else $error("failure flag cleared during fail-safe");
    sleep_clear_a: assert property (clk_en_in && sleep_cmd_in && state_reg == csf_pkg::CSF_ST_RUN
                                    && !fail_det |=> !failsafe_reg && !sys_clk_run_out)
        else $error("sleep did not clear fail-safe");
    ost_end_a: assert property (clk_en_in && state_reg == csf_pkg::CSF_ST_OST && ost_end
                                |=> state_reg == csf_pkg::CSF_ST_RUN && done_reg)
        else $error("start-up count end not taken");
    ost_hold_a: assert property (state_reg == csf_pkg::CSF_ST_OST && !fast_start_reg
                                 && $stable(two_speed_reg) && $stable(mon_en_reg) |-> cpu_hold_out)
        else $error("cpu ran during start-up count");
    ec_start_a: assert property (clk_en_in && state_reg == csf_pkg::CSF_ST_POWER_UP_DELAY_TIMER && !scs_reg
                                 && clock_mode_in == csf_pkg::MODE_EC
                                 |=> state_reg == csf_pkg::CSF_ST_RUN && !cpu_hold_out)
        else $error("logic clock mode delayed start");
    done_low_a: assert property (state_reg == csf_pkg::CSF_ST_OST |-> !done_reg)
        else $error("start-up done set during start-up");
    mon_quiet_a: assert property (state_reg != csf_pkg::CSF_ST_RUN |-> !fail_det)
        else $error("monitor active outside run");
    freeze_a: assert property (!clk_en_in |=> $stable(state_reg) && $stable(ost_cnt_reg)
                               && $stable(flag_reg))
        else $error("state moved while clock stopped");

    fail_seen_c: cover property (clk_en_in && fail_det);
    ost_done_c: cover property (state_reg == csf_pkg::CSF_ST_OST ##1 state_reg == csf_pkg::CSF_ST_RUN);
    wake_c: cover property (state_reg == csf_pkg::CSF_ST_SLEEP ##1 state_reg != csf_pkg::CSF_ST_SLEEP);

endmodule // csf_clock_control

`default_nettype wire

// [verification/csf_osc_model.sv]
// behavioural external crystal or logic clock source on the primary pin
`timescale 1ns/100ps
`default_nettype none
module csf_osc_model #(
    parameter int HALF = 2
) (
    input wire logic clock_in,
    input wire logic run_in,
    output logic pin_out
);
    // ==========================================================
    // oscillator
    int cnt;
    initial pin_out = 1'b0;
    initial cnt = 0;
    // a stopped source stands still low, so a dead crystal shows no edges
    always @(posedge clock_in)
    begin
        if (!run_in)
            pin_out <= 1'b0;
        else if (cnt == HALF - 1)
        begin
            cnt <= 0;
            pin_out <= ~pin_out;
        end
        else
            cnt <= cnt + 1;
    end
endmodule // csf_osc_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the clock start-up and fail-safe controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ==========================================================
    // stimulus and design wiring
    logic clock_in = 1'b0, reset_n_in = 1'b0, rd = 1'b0, wr = 1'b0, rd_q = 1'b0;
    logic sleep_cmd = 1'b0, wake = 1'b0, osc_run = 1'b0, pin;
    logic clk_en = 1'b1, power_up_delay_timer_en = 1'b1, power_up_delay_timer_done = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, exp_q[$];
    logic [2:0] mode = csf_pkg::MODE_XT, ifs;
    logic src, run, hold, capture_compare_pwm_unit, tick, gpio, fsafe, flag;
    logic [31:0] rnd = 32'hc385;
    int error_cnt = 0, cmp_count = 0, edges = 0, i;
    always #5 clock_in = ~clock_in;
    csf_osc_model #(.HALF(2)) osc (.clock_in(clock_in), .run_in(osc_run), .pin_out(pin));
    csf_clock_control uut (.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .clock_mode_in(mode), .power_up_delay_en_in(power_up_delay_timer_en),
        .power_up_delay_done_in(power_up_delay_timer_done), .sleep_cmd_in(sleep_cmd), .wake_in(wake),
        .primary_osc_input_pin_in(pin), .sys_clk_src_out(src), .sys_clk_run_out(run),
        .cpu_hold_out(hold), .ccp_clk_src_out(capture_compare_pwm_unit), .internal_osc_clock_out(tick),
        .internal_freq_select_out(ifs), .secondary_osc_pin_gpio_out(gpio),
        .failsafe_out(fsafe), .osc_failure_flag_out(flag));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clock_in);
        wr <= 1'b0;
    endtask
    // the expectation is queued by the driver, the monitor below compares it
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clock_in);
        rd <= 1'b1; addr <= a;
        @(posedge clock_in);
        rd <= 1'b0;
    endtask
    task automatic pulse_sleep(input logic w);
        @(posedge clock_in);
        if (w) wake <= 1'b1; else sleep_cmd <= 1'b1;
        @(posedge clock_in);
        wake <= 1'b0; sleep_cmd <= 1'b0;
    endtask
    // waits bounded for the switch to the external clock, counting oscillator edges meanwhile;
    // src rather than hold, so a two-speed start is timed the same way
    task automatic await_start();
        edges = 0;
        for (i = 0; i < 6000 && src !== 1'b0; i++)
        begin
            @(posedge pin or negedge src);
            if (pin === 1'b1 && src === 1'b1) edges++;
        end
        check({7'h0, edges >= 1024 && edges <= 1026}, 8'h01);
        @(negedge clock_in);
        check({src, hold, capture_compare_pwm_unit}, 3'b000);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // read data monitor: the answer stands only in the cycle after the strobe
    always @(posedge clock_in) rd_q <= rd;
    always @(negedge clock_in)
    begin
        if (rd_q && exp_q.size() > 0) check(rdata, exp_q.pop_front());
    end
    // ==========================================================
    // watchdog
    initial
    begin
        #500us;
        error_cnt++;
        tally_and_finish();
    end
    // ==========================================================
    // main sequence
    initial
    begin
        osc_run = 1'b1;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        rd_reg(csf_pkg::ADDR_OSC_CTRL, 8'h60);
        @(negedge clock_in);
        check({7'h0, hold}, 8'h01);
        // the crystal count must wait for the power-up delay to expire
        repeat (20) @(posedge clock_in);
        power_up_delay_timer_done <= 1'b1;
        await_start();
        rd_reg(csf_pkg::ADDR_OSC_CTRL, 8'h68);
        rnd = lfsr(rnd);
        wr_reg({1'b1, rnd[2:0]}, rnd[15:8]);
        rd_reg({1'b1, rnd[2:0]}, 8'h00);
        // enable the monitor, then kill the crystal
        wr_reg(csf_pkg::ADDR_OSC_CTRL, 8'h64);
        osc_run <= 1'b0;
        for (i = 0; i < 10000 && fsafe !== 1'b1; i++) @(posedge clock_in);
        @(negedge clock_in);
        check({fsafe, flag, src, capture_compare_pwm_unit}, 4'hf);
        wr_reg(csf_pkg::ADDR_OSC_STAT, 8'h01);
        rd_reg(csf_pkg::ADDR_OSC_STAT, 8'h03);
        wr_reg(csf_pkg::ADDR_OSC_CTRL, 8'h34);
        @(negedge clock_in);
        check({fsafe, ifs}, 4'hb);
        wr_reg(csf_pkg::ADDR_OSC_CTRL, 8'h35);
        osc_run <= 1'b1;
        wr_reg(csf_pkg::ADDR_OSC_STAT, 8'h01);
        rd_reg(csf_pkg::ADDR_OSC_STAT, 8'h00);
        wr_reg(csf_pkg::ADDR_OSC_CTRL, 8'h62);
        // sleep stops the system clock and internal oscillators, wake reruns the start-up count in two-speed mode
        pulse_sleep(1'b0);
        @(negedge clock_in);
        check({7'h0, run}, 8'h00);
        rd_reg(csf_pkg::ADDR_OSC_STAT, 8'h04);
        pulse_sleep(1'b1);
        fork
            await_start();
            begin
                @(negedge clock_in);
                check({6'h0, hold, src}, 8'h01);
                rd_reg(csf_pkg::ADDR_OSC_CTRL, 8'h62);
            end
        join
        // internal mode holds the cpu for the start-up delay after reset
        mode <= csf_pkg::MODE_INT;
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        for (i = 0; i < 1000 && hold !== 1'b0; i++) @(negedge clock_in);
        check({7'h0, i == csf_pkg::CPU_DELAY_CYC + 2}, 8'h01);
        check({7'h0, src}, 8'h01);
        // logic clock mode runs at the first edge after reset
        mode <= csf_pkg::MODE_EC;
        reset_n_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        reset_n_in <= 1'b1;
        @(posedge clock_in);
        @(negedge clock_in);
        check({hold, src, gpio, fsafe}, 4'h2);
        // reset frequency select 6 gives half the fast rate
        edges = 0;
        repeat (240) @(negedge clock_in) edges += tick;
        check(edges[7:0], 8'(240 / (csf_pkg::FAST_DIV * 2)));
        // a stopped clock freezes all state, so a sleep seen only then is lost
        @(posedge clock_in);
        clk_en <= 1'b0;
        sleep_cmd <= 1'b1;
        repeat (3) @(posedge clock_in);
        clk_en <= 1'b1;
        sleep_cmd <= 1'b0;
        @(negedge clock_in);
        check({7'h0, run}, 8'h01);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
